// [pesec_monitor.sv]
// Purpose: Bus timing and read data checks on pesec_top ports.
// Assumes: One wait state per access.
// Notes: Register state is not visible here.
`timescale 1ns/1ps
module pesec_monitor (
  input wire core_clk,
  input wire rst_n,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire req = avs_read || avs_write;
  wire tk = req && avs_waitrequest;
  a_ack_one_cycle: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("wait low too long");
  a_req_answered: assert property (tk |=> !avs_waitrequest)
    else $error("no answer");
  a_ack_needs_req: assert property ($fell(avs_waitrequest) |-> $past(req))
    else $error("answer without request");
  a_rdata_source: assert property ($changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
    else $error("read data moved");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(req) || $past(req, 2))
    else $error("irq dropped alone");
  a_unaligned_zero: assert property (tk && avs_read && avs_address[1:0] != 2'h0
    |=> avs_readdata == 32'h00000000)
    else $error("unaligned read not zero");
  a_reserved_zero: assert property (tk && avs_read && avs_address == 8'h4C
    |=> avs_readdata[13:12] == 2'h0 && avs_readdata[5:4] == 2'h0)
    else $error("reserved bits set");
  a_fc_high_zero: assert property (tk && avs_read && avs_address == 8'h50
    |=> avs_readdata[31:8] == 24'h000000)
    else $error("count upper byte set");
  cover property (tk && avs_read);
  cover property ($rose(irq));
  cover property ($fell(irq));
endmodule // pesec_monitor
bind pesec_top pesec_monitor pesec_monitor_inst (.core_clk(core_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));

// [pesec_regs.vh]
// Purpose: Register map, field positions, reset values and limits for the
//          PHY event status and error counter block.
// Assumes: Avalon-MM byte addresses, one 32-bit word per register.
// Notes:   Register index times four gives the byte address.
`ifndef PESEC_REGS_VH
`define PESEC_REGS_VH

// Register indices (byte address = index * 4)
`define PESEC_IDX_ONE 6'h12
`define PESEC_IDX_TWO 6'h13
`define PESEC_IDX_FC 6'h14
`define PESEC_IDX_RE 6'h15
`define PESEC_IDX_STAT 6'h1A
`define PESEC_IDX_MASK 6'h1B

// Event vector positions, shared by status and mask registers
`define PESEC_EV_UV 7
`define PESEC_EV_OV 6
`define PESEC_EV_OT 5
`define PESEC_EV_SLEEP 4
`define PESEC_EV_POL 3
`define PESEC_EV_JAB 2
`define PESEC_EV_FC_HF 1
`define PESEC_EV_RE_HF 0

// Events owned by each register of the pair
`define PESEC_TWO_EVENTS 8'hFC
`define PESEC_ONE_EVENTS 8'h03

// Reset values
`define PESEC_PEND_RST 8'h00
`define PESEC_EN_RST 8'h00
`define PESEC_MASK_RST 8'hFF
`define PESEC_FC_RST 8'h00
`define PESEC_RE_RST 16'h0000

// Counter limits
`define PESEC_FC_MAX 8'hFF
`define PESEC_FC_HALF 8'h7F
`define PESEC_RE_MAX 16'hFFFF
`define PESEC_RE_HALF 16'h7FFF

`endif

// [pesec_top.v]
// Purpose: Latched event flags, enables, false-carrier and receive-error
//          counters of a single-pair Ethernet PHY, on an Avalon-MM slave.
// Assumes: All event inputs synchronous to core_clk; one wait state per access.
// Notes:   Pending flags clear on read of their register or by write-one-clear
//          at the status alias; a new event in the same cycle wins.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
`include "pesec_regs.vh"

// Operation
// - Undervoltage flag latched in bit 15
// - Overvoltage flag latched in bit 14
// - Overtemperature flag latched in bit 11
// - Sleep-mode flag latched in bit 10
// - Polarity change flag latched in bit 9
// - Jabber flag latched in bit 8
// - Enable bits, reset zero, reserved read zero
// - False-carrier count in low byte
// - False-carrier count saturates at 0xFF
// - False-carrier passing 0x7F raises event
// - Counters clear on each read
// - Receive errors counted while data valid
// - Receive-error count frozen in loopback
// - Receive-error count saturates at full scale
// - Receive-error passing 0x7FFF raises event
// - False-carrier half-full in register one bit 9
// - Receive-error half-full in register one bit 8
module pesec_top (
  input wire core_clk,
  input wire rst_n,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire undervoltage_evt,
  input wire overvoltage_evt,
  input wire overtemp_evt,
  input wire sleep_evt,
  input wire rx_polarity,
  input wire jabber_evt,
  input wire false_carrier_evt,
  input wire rx_dv,
  input wire rx_symbol_err,
  input wire mac_loopback,
  output reg irq
);

  reg [7:0] pend_q;
  reg [7:0] pend_d;
  reg [7:0] en_q;
  reg [7:0] en_d;
  reg [7:0] mask_q;
  reg [7:0] mask_d;
  reg [7:0] fc_q;
  reg [7:0] fc_d;
  reg [15:0] re_q;
  reg [15:0] re_d;
  reg pol_q;
  reg pol_seen_q;
  reg [31:0] rd_mux;
  reg [7:0] clr;
  wire [5:0] idx;
  wire aligned;
  wire rd_cap;
  wire wr_do;
  wire lane0;
  wire rd_one;
  wire rd_two;
  wire rd_fc;
  wire rd_re;
  wire pol_chg;
  wire fc_inc;
  wire re_evt;
  wire re_inc;
  wire fc_hf;
  wire re_hf;
  wire [7:0] ev;

  assign idx = avs_address[7:2];
  assign aligned = (avs_address[1:0] == 2'h0);
  // Read data and side effects land on the first edge, one per transfer
  assign rd_cap = avs_read & avs_waitrequest & aligned;
  // Writes take effect only on the edge where waitrequest is seen low
  assign wr_do = avs_write & ~avs_waitrequest & aligned;
  assign lane0 = avs_byteenable[0];
  assign rd_one = rd_cap & (idx == `PESEC_IDX_ONE);
  assign rd_two = rd_cap & (idx == `PESEC_IDX_TWO);
  assign rd_fc = rd_cap & (idx == `PESEC_IDX_FC);
  assign rd_re = rd_cap & (idx == `PESEC_IDX_RE);

  // polarity edge
  // First sample after reset only primes the history, no false change
  assign pol_chg = pol_seen_q & (rx_polarity != pol_q);

  assign fc_inc = false_carrier_evt & (fc_q != `PESEC_FC_MAX);
  assign re_evt = rx_dv & rx_symbol_err & ~mac_loopback;
  assign re_inc = re_evt & (re_q != `PESEC_RE_MAX);
  assign fc_hf = fc_inc & ~rd_fc & (fc_q == `PESEC_FC_HALF);
  assign re_hf = re_inc & ~rd_re & (re_q == `PESEC_RE_HALF);

  assign ev = {undervoltage_evt, overvoltage_evt, overtemp_evt, sleep_evt,
               pol_chg, jabber_evt, fc_hf, re_hf};

  always @* begin
    clr = 8'h00;
    if (rd_two) begin
      clr = clr | `PESEC_TWO_EVENTS;
    end
    if (rd_one) begin
      clr = clr | `PESEC_ONE_EVENTS;
    end
    if (wr_do && lane0 && idx == `PESEC_IDX_STAT) begin
      clr = clr | avs_writedata[7:0];
    end
    pend_d = (pend_q & ~clr) | ev;
  end

  always @* begin
    en_d = en_q;
    mask_d = mask_q;
    if (wr_do && lane0) begin
      if (idx == `PESEC_IDX_TWO) begin
        en_d[7:2] = {avs_writedata[7:6], avs_writedata[3:0]};
      end
      if (idx == `PESEC_IDX_ONE) begin
        en_d[1:0] = avs_writedata[1:0];
      end
      if (idx == `PESEC_IDX_MASK) begin
        mask_d = avs_writedata[7:0];
      end
    end
  end

  always @* begin
    fc_d = fc_q;
    re_d = re_q;
    // clear on read
    // An event on the read edge counts into the fresh value
    if (rd_fc) begin
      fc_d = {7'h00, false_carrier_evt};
    end else if (fc_inc) begin
      fc_d = fc_q + 8'h01;
    end
    if (rd_re) begin
      re_d = {15'h0000, re_evt};
    end else if (re_inc) begin
      re_d = re_q + 16'h0001;
    end
  end

  always @* begin
    rd_mux = 32'h00000000;
    case (idx)
      `PESEC_IDX_ONE: begin
        rd_mux[15:0] = {6'h00, pend_q[1:0], 6'h00, en_q[1:0]};
      end
      `PESEC_IDX_TWO: begin
        rd_mux[15:0] = {pend_q[7:6], 2'h0, pend_q[5:2], en_q[7:6], 2'h0, en_q[5:2]};
      end
      `PESEC_IDX_FC: begin
        rd_mux[15:0] = {8'h00, fc_q};
      end
      `PESEC_IDX_RE: begin
        rd_mux[15:0] = re_q;
      end
      `PESEC_IDX_STAT: begin
        rd_mux[7:0] = pend_q;
      end
      `PESEC_IDX_MASK: begin
        rd_mux[7:0] = mask_q;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
    if (!aligned) begin
      rd_mux = 32'h00000000;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= `PESEC_PEND_RST;
      en_q <= `PESEC_EN_RST;
      mask_q <= `PESEC_MASK_RST;
      fc_q <= `PESEC_FC_RST;
      re_q <= `PESEC_RE_RST;
      pol_q <= 1'b0;
      pol_seen_q <= 1'b0;
      avs_readdata <= 32'h00000000;
      avs_waitrequest <= 1'b1;
      irq <= 1'b0;
    end else begin
      pend_q <= pend_d;
      en_q <= en_d;
      mask_q <= mask_d;
      fc_q <= fc_d;
      re_q <= re_d;
      pol_q <= rx_polarity;
      pol_seen_q <= 1'b1;
      // One wait state; drops for exactly one edge per request
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
      irq <= |(pend_q & en_q & mask_q);
    end
  end

endmodule // pesec_top

// [pesec_top_test.sv]
// Purpose: Register level test of pesec_top.
// Assumes: One request at a time on the slave port.
// Notes: Receive-error run is long to reach saturation.
`timescale 1ns/1ps
module pesec_top_test;
  reg core_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] adr = 8'h00;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wd = 32'h0;
  reg [5:0] ev = 6'h00;
  reg fc = 1'b0;
  reg [2:0] re = 3'h0;
  wire [31:0] rdat;
  wire wreq;
  wire irq;
  reg [15:0] got;
  int error_cnt = 0;
  int checked = 0;
  always #4 core_clk = ~core_clk;
  pesec_top pesec_top_inst (.core_clk(core_clk), .rst_n(rst_n), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .undervoltage_evt(ev[5]),
    .overvoltage_evt(ev[4]), .overtemp_evt(ev[3]), .sleep_evt(ev[2]),
    .rx_polarity(ev[1]), .jabber_evt(ev[0]), .false_carrier_evt(fc), .rx_dv(re[1]),
    .rx_symbol_err(re[0]), .mac_loopback(re[2]), .irq(irq));
  task summarize;
    $display("errors=%0d checks=%0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Bounded wait so a missing answer cannot hang the run
  task acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= {16'h0000, d};
    @(posedge core_clk);
    while (wreq !== 1'b0 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 20) begin
      error_cnt++;
      summarize;
    end
    got = rdat[15:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    chk(got, e);
  endtask
  initial begin
    cyc(2);
    rst_n <= 1'b1;
    rdc(8'h4C, 16'h0000);
    rdc(8'h6C, 16'h00FF);
    rdc(8'h50, 16'h0000);
    rdc(8'h54, 16'h0000);
    acc(1'b1, 8'h4C, 16'hFFFF);
    acc(1'b1, 8'h48, 16'hFFFF);
    rdc(8'h4C, 16'h00CF);
    rdc(8'h48, 16'h0003);
    ev <= 6'h3F;
    cyc(1);
    ev <= 6'h00;
    cyc(3);
    chk(irq, 1'b1);
    rdc(8'h4C, 16'hCFCF);
    rdc(8'h4C, 16'h00CF);
    chk(irq, 1'b0);
    acc(1'b1, 8'h6C, 16'h0000);
    ev <= 6'h20;
    cyc(1);
    ev <= 6'h00;
    cyc(3);
    chk(irq, 1'b0);
    rdc(8'h68, 16'h0080);
    acc(1'b1, 8'h68, 16'h0080);
    rdc(8'h68, 16'h0000);
    acc(1'b1, 8'h6C, 16'h00FF);
    fc <= 1'b1;
    cyc(300);
    fc <= 1'b0;
    rdc(8'h50, 16'h00FF);
    rdc(8'h50, 16'h0000);
    // Loopback, no valid, no error: none may count
    re <= 3'b111;
    cyc(5);
    re <= 3'b001;
    cyc(5);
    re <= 3'b010;
    cyc(5);
    re <= 3'b011;
    cyc(4);
    re <= 3'b000;
    rdc(8'h54, 16'h0004);
    re <= 3'b011;
    cyc(66000);
    re <= 3'b000;
    chk(irq, 1'b1);
    rdc(8'h54, 16'hFFFF);
    rdc(8'h48, 16'h0303);
    rdc(8'h49, 16'h0000);
    acc(1'b1, 8'h7C, 16'h00FF);
    rdc(8'h7C, 16'h0000);
    summarize;
  end
  // About 66400 cycles expected
  initial begin
    #700000;
    error_cnt++;
    summarize;
  end
endmodule // pesec_top_test
